// File: logic/wsi_pkg.sv
package wsi_pkg;
  // =====================================================
  // Wiper and address constants
  // =====================================================
  localparam int WIPER_W = 7;
  localparam logic [6:0] WIPER_MID = 7'h40;
  localparam logic [6:0] SLV_ADDR_0 = 7'h2e;
  localparam logic [6:0] SLV_ADDR_1 = 7'h17;
  localparam logic [6:0] SLV_ADDR_2 = 7'h16;
  localparam logic [1:0] ADDR_SEL_DEF = 2'h0;
  // =====================================================
  // Serial framing
  // =====================================================
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int RW_BIT = 0;
  localparam logic RW_READ = 1'b1;
  localparam int SYNC_STAGES = 3;
  // =====================================================
  // Slave states, one-hot
  // =====================================================
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ACKA = 8'h04,
    ST_WRX  = 8'h08,
    ST_ACKW = 8'h10,
    ST_RDX  = 8'h20,
    ST_ACKR = 8'h40,
    ST_IGN  = 8'h80
  } wsi_state_e;
endpackage

// File: logic/wsi_line_if.sv
interface wsi_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, output sda, output scl_rise, output scl_fall, output start,
    output stop);
  modport dst (input scl, input sda, input scl_rise, input scl_fall, input start,
    input stop);
endinterface

// File: logic/wsi_line_sync.sv
module wsi_line_sync
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  wsi_line_if.src ln
);
  import wsi_pkg::*;

  // =====================================================
  // Three-stage sampling; a change counts once stages two and three agree
  // =====================================================
  logic [SYNC_STAGES-1:0] scl_sh_r;
  logic [SYNC_STAGES-1:0] sda_sh_r;
  logic [SYNC_STAGES-1:0] scl_sh_nxt;
  logic [SYNC_STAGES-1:0] sda_sh_nxt;
  logic scl_r;
  logic sda_r;
  logic scl_nxt;
  logic sda_nxt;

  always_comb
  begin
    scl_sh_nxt = {scl_sh_r[SYNC_STAGES-2:0], scl_i};
    sda_sh_nxt = {sda_sh_r[SYNC_STAGES-2:0], sda_i};
    scl_nxt = (scl_sh_r[1] == scl_sh_r[2]) ? scl_sh_r[2] : scl_r;
    sda_nxt = (sda_sh_r[1] == sda_sh_r[2]) ? sda_sh_r[2] : sda_r;
  end

  // Idle bus level is high, so reset there to avoid a false start
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      scl_sh_r <= 3'h7;
      sda_sh_r <= 3'h7;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end
    else
    begin
      scl_sh_r <= scl_sh_nxt;
      sda_sh_r <= sda_sh_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end

  // =====================================================
  // Edge and condition detection on the filtered levels
  // =====================================================
  assign ln.scl = scl_r;
  assign ln.sda = sda_r;
  assign ln.scl_rise = scl_nxt && !scl_r;
  assign ln.scl_fall = !scl_nxt && scl_r;
  assign ln.start = scl_r && scl_nxt && sda_r && !sda_nxt;
  assign ln.stop = scl_r && scl_nxt && !sda_r && sda_nxt;
endmodule

// File: logic/wsi_top.sv
// Functional notes
// - First byte after start: seven address bits, then direction, 0 write, 1 read.
// - Data falling while clock high is a start condition.
// - On address match, hold data low through the ninth clock pulse.
// - On mismatch, stay idle with data released until the transfer ends.
// - In write direction, each following byte: eight data bits plus acknowledge.
// - Data changes only while clock low, stable while clock high.
// - In read direction, shift out eight bits then an acknowledge slot.
// - Data rising while clock high is a stop; return to idle.
// - After one write address, every further byte updates the wiper.
// - After one read address, every byte up to the master's not-acknowledge returns the wiper value.
// - Slave address is fixed at build time, one of three choices.
// - Wiper register is seven bits, one of 128 taps.
// - Reset presets the wiper to midscale without bus access.
module wsi_top
#(
  parameter logic [1:0] ADDR_SEL = wsi_pkg::ADDR_SEL_DEF
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic [wsi_pkg::WIPER_W-1:0] wiper_setting_register
);
  import wsi_pkg::*;

  // =====================================================
  // Line conditioning
  // =====================================================
  wsi_line_if ln ();

  wsi_line_sync u_sync
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ln(ln)
  );

  // Address strap is a build-time choice; unused codes fall back to the first
  localparam logic [6:0] OWN_ADDR = (ADDR_SEL == 2'h1) ? SLV_ADDR_1 :
    (ADDR_SEL == 2'h2) ? SLV_ADDR_2 : SLV_ADDR_0;

  // =====================================================
  // Slave state
  // =====================================================
  wsi_state_e st_r;
  wsi_state_e st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic rw_r;
  logic rw_nxt;
  logic nack_r;
  logic nack_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [6:0] wiper_r;
  logic [6:0] wiper_nxt;
  logic byte_done;

  assign byte_done = ln.scl_fall && (cnt_r == BITS_PER_BYTE);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    oe_nxt = oe_r;
    wiper_nxt = wiper_r;
    if (ln.start)
    begin
      // A start in any state, including a repeated one, restarts addressing
      st_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end
    else if (ln.stop)
    begin
      st_nxt = ST_IDLE;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          oe_nxt = 1'b0;
        end
        ST_ADDR, ST_WRX:
        begin
          // Sample on the rising clock where data is stable
          if (ln.scl_rise && cnt_r < BITS_PER_BYTE)
          begin
            sh_nxt = {sh_r[6:0], ln.sda};
            cnt_nxt = cnt_r + 4'h1;
          end
          if (byte_done && st_r == ST_ADDR)
          begin
            rw_nxt = sh_r[RW_BIT];
            if (sh_r[7:1] == OWN_ADDR)
            begin
              st_nxt = ST_ACKA;
              oe_nxt = 1'b1;
            end
            else
            begin
              st_nxt = ST_IGN;
            end
          end
          else if (byte_done)
          begin
            // Only a whole byte reaches the wiper
            wiper_nxt = sh_r[6:0];
            st_nxt = ST_ACKW;
            oe_nxt = 1'b1;
          end
        end
        ST_ACKA:
        begin
          if (ln.scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (rw_r == RW_READ)
            begin
              st_nxt = ST_RDX;
              sh_nxt = {1'b0, wiper_r};
              oe_nxt = 1'b1;
            end
            else
            begin
              st_nxt = ST_WRX;
              oe_nxt = 1'b0;
            end
          end
        end
        ST_ACKW:
        begin
          if (ln.scl_fall)
          begin
            st_nxt = ST_WRX;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
          end
        end
        ST_RDX:
        begin
          if (ln.scl_rise)
          begin
            cnt_nxt = cnt_r + 4'h1;
          end
          if (byte_done)
          begin
            st_nxt = ST_ACKR;
            oe_nxt = 1'b0;
          end
          else if (ln.scl_fall)
          begin
            // Next bit only changes while the clock is low
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_nxt = !sh_r[6];
          end
        end
        ST_ACKR:
        begin
          if (ln.scl_rise)
          begin
            nack_nxt = ln.sda;
          end
          if (ln.scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (nack_r)
            begin
              st_nxt = ST_IGN;
              oe_nxt = 1'b0;
            end
            else
            begin
              st_nxt = ST_RDX;
              sh_nxt = {1'b0, wiper_r};
              oe_nxt = 1'b1;
            end
          end
        end
        ST_IGN:
        begin
          oe_nxt = 1'b0;
        end
        default:
        begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      oe_r <= 1'b0;
      wiper_r <= WIPER_MID;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      oe_r <= oe_nxt;
      wiper_r <= wiper_nxt;
    end
  end

  // Open-drain: the pad level is always low, only the enable moves
  always_ff @(posedge mclk)
  begin
    sda_o <= 1'b0;
  end

  assign sda_oe = oe_r;
  assign wiper_setting_register = wiper_r;

  // =====================================================
  // Checks
  // =====================================================
  AST_START_ADDR: assert property (@(posedge mclk) disable iff (sys_rst)
    ln.start |=> st_r == ST_ADDR && !oe_r)
    else $error("start did not enter addressing");
  AST_STOP_IDLE: assert property (@(posedge mclk) disable iff (sys_rst)
    ln.stop && !ln.start |=> st_r == ST_IDLE && !oe_r)
    else $error("stop did not return to idle");
  AST_ADDR_ACK: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r == ST_ADDR && byte_done && !ln.start && !ln.stop && sh_r[7:1] == OWN_ADDR
    |=> st_r == ST_ACKA && oe_r)
    else $error("matching address not acknowledged");
  AST_ADDR_MISS: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r == ST_ADDR && byte_done && !ln.start && !ln.stop && sh_r[7:1] != OWN_ADDR
    |=> st_r == ST_IGN)
    else $error("foreign address not ignored");
  AST_IGN_RELEASE: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r == ST_IGN |-> !oe_r)
    else $error("data driven while not selected");
  AST_WR_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r == ST_WRX && byte_done && !ln.start && !ln.stop |=> wiper_r == $past(sh_r[6:0]))
    else $error("written byte not loaded");
  AST_WR_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    !$stable(wiper_r) && !$past(sys_rst) |-> $past(st_r == ST_WRX && byte_done))
    else $error("wiper changed without a whole byte");
  AST_RD_FIRST: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r == ST_ACKA && ln.scl_fall && rw_r && !ln.start && !ln.stop
    |=> st_r == ST_RDX && oe_r && sh_r == {1'b0, wiper_r})
    else $error("read byte not loaded with zero and wiper");
  AST_RD_REPEAT: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r == ST_ACKR && ln.scl_fall && !nack_r && !ln.start && !ln.stop |=> st_r == ST_RDX)
    else $error("acknowledged read did not continue");
  AST_OE_TIMING: assert property (@(posedge mclk) disable iff (sys_rst)
    !$stable(oe_r) && !$past(sys_rst) |-> $past(ln.scl_fall || ln.start || ln.stop))
    else $error("data drive changed outside clock low");
  AST_DRV_CLK_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
    !$stable(oe_r) && !$past(sys_rst) && !$past(ln.start || ln.stop) |-> !ln.scl)
    else $error("data drive changed while clock high");
  AST_RESET_MID: assert property (@(posedge mclk)
    sys_rst |=> wiper_r == WIPER_MID)
    else $error("wiper not at midscale after reset");
endmodule

// File: dv/wsi_master_model.sv
module wsi_master_model
(
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // Idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // ====================
  // Bit timing: 5 mclk low, 3 mclk high, 400 ns per bit
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // From idle, or a repeated start when the clock is low
  task automatic start();
    if (scl === 1'b0)
    begin
      tick(1);
      sda_oe = 1'b0;
      tick(4);
      scl = 1'b1;
    end
    tick(4);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask
  // Data moves one mclk after the fall so the slave never sees it as a start or stop
  task automatic clk_bit(input logic b, output logic s);
    tick(1);
    sda_oe = ~b;
    tick(4);
    scl = 1'b1;
    tick(3);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~ack, s);
  endtask
endmodule

// File: dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import wsi_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic ack;
    logic [6:0] wiper;
  } wsi_row_s;
  localparam wsi_row_s ROWS [6] = '{
    '{{SLV_ADDR_0, 1'b0}, 8'h15, 1'b1, 7'h15},
    '{{SLV_ADDR_0, 1'b0}, 8'hff, 1'b1, 7'h7f},
    '{{SLV_ADDR_1, 1'b0}, 8'h00, 1'b0, 7'h7f},
    '{{SLV_ADDR_2, 1'b0}, 8'h00, 1'b1, 7'h7f},
    '{{SLV_ADDR_0, 1'b0}, 8'h80, 1'b1, 7'h00},
    '{{SLV_ADDR_0, 1'b0}, 8'h2a, 1'b1, 7'h2a}};
  localparam logic [7:0] MULTI [3] = '{8'h01, 8'hfe, 8'h33};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl;
  logic mst_oe;
  logic sda_o;
  logic sda_oe;
  logic sda_line;
  logic [WIPER_W-1:0] wiper;
  logic sda_oe_b;
  logic [WIPER_W-1:0] wiper_b;
  int n_fail = 0;
  int checks = 0;
  // Pulled-up open-drain data wire shared by both slaves and the master
  assign sda_line = ~(sda_oe | sda_oe_b | mst_oe);
  always #25 mclk = ~mclk;
  wsi_top i_dut
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wiper_setting_register(wiper)
  );
  // Second slave strapped to the third address, so one bus holds two selectable devices
  wsi_top #(.ADDR_SEL(2'h2)) i_dut_b
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(),
    .sda_oe(sda_oe_b),
    .wiper_setting_register(wiper_b)
  );
  wsi_master_model i_mst
  (
    .mclk(mclk),
    .sda(sda_line),
    .scl(scl),
    .sda_oe(mst_oe)
  );
  // ====================
  // Checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset(input int n);
    @(posedge mclk);
    #1;
    sys_rst = 1'b1;
    repeat (n) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // About 2000 mclk of traffic; generous margin before giving up
  initial
  begin
    #400us;
    n_fail++;
    stop_test();
  end
  // ====================
  // Main sequence
  initial
  begin
    logic ack;
    logic [7:0] rd;
    repeat (2) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
    check({1'b0, wiper}, {1'b0, WIPER_MID});
    check({1'b0, wiper_b}, {1'b0, WIPER_MID});
    check({6'h00, sda_o, sda_oe}, 8'h00);
    foreach (ROWS[i])
    begin
      i_mst.start();
      i_mst.wr_byte(ROWS[i].addr, ack);
      check({7'h00, ack}, {7'h00, ROWS[i].ack});
      i_mst.wr_byte(ROWS[i].data, ack);
      check({7'h00, ack}, {7'h00, ROWS[i].ack});
      i_mst.stop();
      check({1'b0, wiper}, {1'b0, ROWS[i].wiper});
    end
    // The second slave took only the byte sent to its own address
    check({1'b0, wiper_b}, 8'h00);
    // Read twice under one address, then no acknowledge
    i_mst.start();
    i_mst.wr_byte({SLV_ADDR_0, RW_READ}, ack);
    check({7'h00, ack}, 8'h01);
    i_mst.rd_byte(1'b1, rd);
    check(rd, 8'h2a);
    i_mst.rd_byte(1'b0, rd);
    check(rd, 8'h2a);
    i_mst.stop();
    check({7'h00, sda_oe}, 8'h00);
    // Back-to-back writes, then a repeated start into read
    i_mst.start();
    i_mst.wr_byte({SLV_ADDR_0, 1'b0}, ack);
    foreach (MULTI[i])
    begin
      i_mst.wr_byte(MULTI[i], ack);
      check({1'b0, wiper}, {1'b0, MULTI[i][6:0]});
    end
    i_mst.start();
    i_mst.wr_byte({SLV_ADDR_0, RW_READ}, ack);
    check({7'h00, ack}, 8'h01);
    i_mst.rd_byte(1'b0, rd);
    check(rd, 8'h33);
    i_mst.stop();
    // Stop after four data bits
    i_mst.start();
    i_mst.wr_byte({SLV_ADDR_0, 1'b0}, ack);
    repeat (4) i_mst.clk_bit(1'b0, ack);
    i_mst.stop();
    check({1'b0, wiper}, 8'h33);
    // Foreign address in read direction leaves the line released
    i_mst.start();
    i_mst.wr_byte({SLV_ADDR_1, RW_READ}, ack);
    check({7'h00, ack}, 8'h00);
    i_mst.rd_byte(1'b0, rd);
    check(rd, 8'hff);
    i_mst.stop();
    do_reset(2);
    check({1'b0, wiper}, {1'b0, WIPER_MID});
    check({1'b0, wiper_b}, {1'b0, WIPER_MID});
    stop_test();
  end
endmodule
